// ==== include/tmc_pkg.sv ====
// constants, codes and carrier types of the temperature measure control
package tmc_pkg;

  // ***************************************************
  // clock and timing
  // ***************************************************
  localparam int CLK_HZ         = 100_000_000;
  localparam int COMMIT_MS      = 6;
  localparam int COMMIT_CYCLES  = COMMIT_MS * (CLK_HZ / 1000);

  // ***************************************************
  // register indices (byte address = 4 * index)
  // ***************************************************
  localparam logic [13:0] IDX_RESULT_HI = 14'h2881;
  localparam logic [13:0] IDX_RESULT_LO = 14'h2882;
  localparam logic [13:0] IDX_BATTERY   = 14'h2885;
  localparam logic [13:0] IDX_CONFIG    = 14'h28A0;
  localparam logic [13:0] IDX_TRIGGER   = 14'h28B4;
  localparam logic [13:0] IDX_IRQ_STAT  = 14'h28C0;
  localparam logic [13:0] IDX_IRQ_MASK  = 14'h28C1;

  // ***************************************************
  // field positions and reset values
  // ***************************************************
  localparam int CFG_BSEL_BIT   = 7;
  localparam int CFG_SUPPLY_BIT = 6;
  localparam int CFG_BATEN_BIT  = 4;
  localparam int CFG_BUSY_BIT   = 3;
  localparam int CFG_PER_MSB    = 2;
  localparam int TRIG_BIT       = 6;
  localparam int LO_FIELD_LSB   = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int IRQ_MEAS_BIT   = 0;
  localparam int IRQ_CFG_BIT    = 1;
  localparam int IRQ_W          = 2;

  // ***************************************************
  // period selector codes and power states
  // ***************************************************
  localparam logic [2:0] PER_MANUAL     = 3'h0;
  localparam logic [2:0] PER_CONTINUOUS = 3'h7;
  localparam int         PER_EXP_BASE   = 3;
  localparam int         RESULT_W       = 11;
  localparam int         BATTERY_W      = 8;

  typedef enum logic [1:0] {
    TMC_FULL_POWER = 2'h0,
    TMC_BROWNOUT   = 2'h1,
    TMC_DISPLAY    = 2'h2,
    TMC_SLEEP      = 2'h3
  } tmc_power_t;

  typedef enum logic [1:0] {
    TMC_IDLE = 2'b01,
    TMC_MEAS = 2'b10
  } tmc_state_t;

  // ***************************************************
  // sensor link carriers
  // ***************************************************
  typedef struct packed {
    logic enable;
    logic battery_meas;
    logic supply_main;
    logic battery_sel;
  } tmc_sense_req_t;

  typedef struct packed {
    logic                   done;
    logic [RESULT_W-1:0]    result;
    logic [BATTERY_W-1:0]   battery;
  } tmc_sense_rsp_t;

endpackage

// ==== test/test_temperature_measure_control.sv ====
// self-checking bench of the temperature measure control
`timescale 1ns/100ps
`default_nettype none
module test_temperature_measure_control;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        cyc_i = 1'h0;
  logic        stb_i = 1'h0;
  logic        we_i  = 1'h0;
  logic [15:0] adr_i = 16'h0000;
  logic [3:0]  sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [1:0]  power_state_i = 2'h0;
  logic        sec_tick_i    = 1'h0;
  logic        irq_o;
  logic [7:0]  lat  = 8'h03;
  logic [10:0] temp = 11'h000;
  logic [7:0]  batt = 8'h00;
  logic        stall = 1'h0;
  logic [7:0]  q;
  tmc_pkg::tmc_sense_req_t sense_req_o;
  tmc_pkg::tmc_sense_rsp_t sense_rsp_i;
  int seed = 32'hA3A4;
  int num_errors = 0;
  int n_tests = 0;
  int v, i, n, k;

  always #5 clk_i = ~clk_i;

  tmc_top #(.COMMIT_CYCLES(8)) i_tmc_top (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .power_state_i(power_state_i), .sec_tick_i(sec_tick_i),
    .irq_o(irq_o), .sense_req_o(sense_req_o), .sense_rsp_i(sense_rsp_i));
  tmc_sensor_model i_tmc_sensor_model (.clk_i(clk_i), .req_i(sense_req_o),
    .lat_i(lat), .temp_i(temp), .batt_i(batt), .stall_i(stall),
    .rsp_o(sense_rsp_i));

  // ***************************************************
  // checks and bus cycles
  // ***************************************************
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: byte %h want %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: flag %b want %b", $time, got, exp);
    end
  endtask
  task wb(input logic w, input logic [13:0] idx, input logic [7:0] d);
    int c;
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i  <= w;
    adr_i <= {idx, 2'h0};
    dat_i <= {24'h0, d};
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
    end while (ack_o !== 1'h1 && c < 50);
    if (ack_o !== 1'h1) chk1(ack_o, 1'h1);
    q = dat_o[7:0];
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
  endtask
  task rd(input logic [13:0] idx, input logic [7:0] exp);
    wb(1'h0, idx, 8'h00);
    chk8(q, exp);
  endtask
  task poll(input logic [13:0] idx, input logic [7:0] m);
    int c;
    c = 0;
    do begin
      wb(1'h0, idx, 8'h00);
      c++;
    end while ((q & m) !== 8'h00 && c < 200);
    if ((q & m) !== 8'h00) chk8(q & m, 8'h00);
  endtask
  task tick(input int t);
    repeat (t) begin
      @(posedge clk_i);
      sec_tick_i <= 1'h1;
      @(posedge clk_i);
      sec_tick_i <= 1'h0;
    end
  endtask
  task wait_en(input logic lvl);
    k = 0;
    while (sense_req_o.enable !== lvl && k < 40) begin
      @(posedge clk_i);
      k++;
    end
  endtask
  task result_chk(input int e);
    logic [10:0] t;
    t = e[10:0];
    rd(tmc_pkg::IDX_RESULT_HI, t[10:3]);
    rd(tmc_pkg::IDX_RESULT_LO, {t[2:0], 5'h00});
  endtask
  task measure(input int e);
    temp <= e[10:0];
    wb(1'h1, tmc_pkg::IDX_TRIGGER, 8'h40);
    poll(tmc_pkg::IDX_TRIGGER, 8'h40);
    result_chk(e);
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // whole run is a few thousand cycles, so 20k cycles means a hang
  initial begin
    #200_000;
    $display("unexpected at %0t: watchdog expired", $time);
    num_errors++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(tmc_pkg::IDX_CONFIG, 8'h00);
    rd(tmc_pkg::IDX_TRIGGER, 8'h00);
    rd(14'h0040, 8'h00);
    chk1(irq_o, 1'h0);
    $display("reset test done");
    for (i = 0; i < 6; i++) begin
      power_state_i <= {1'h0, i[0]};
      v = $random(seed);
      lat <= {5'h00, v[2:0]};
      v = (i == 0) ? -1024 : (i == 1) ? 1023 : $random(seed) % 1024;
      measure(v);
    end
    rd(tmc_pkg::IDX_IRQ_STAT, 8'h01);
    wb(1'h1, tmc_pkg::IDX_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk_i);
    chk1(irq_o, 1'h1);
    wb(1'h1, tmc_pkg::IDX_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk_i);
    chk1(irq_o, 1'h0);
    wb(1'h1, tmc_pkg::IDX_IRQ_MASK, 8'h01);
    wb(1'h1, tmc_pkg::IDX_IRQ_STAT, 8'h01);
    repeat (2) @(posedge clk_i);
    chk1(irq_o, 1'h0);
    rd(tmc_pkg::IDX_IRQ_STAT, 8'h00);
    $display("manual and irq test done");
    power_state_i <= 2'h3;
    wb(1'h1, tmc_pkg::IDX_TRIGGER, 8'h40);
    rd(tmc_pkg::IDX_TRIGGER, 8'h00);
    chk1(sense_req_o.enable, 1'h0);
    power_state_i <= 2'h1;
    wb(1'h1, tmc_pkg::IDX_CONFIG, 8'hD0);
    rd(tmc_pkg::IDX_CONFIG, 8'h08);
    wb(1'h1, tmc_pkg::IDX_CONFIG, 8'h00);
    poll(tmc_pkg::IDX_CONFIG, 8'h08);
    rd(tmc_pkg::IDX_CONFIG, 8'hD0);
    rd(tmc_pkg::IDX_IRQ_STAT, 8'h02);
    v = $random(seed);
    batt <= v[7:0];
    measure(v % 1024);
    rd(tmc_pkg::IDX_BATTERY, v[7:0]);
    chk1(sense_req_o.battery_sel, 1'h1);
    stall <= 1'h1;
    wb(1'h1, tmc_pkg::IDX_CONFIG, 8'h00);
    poll(tmc_pkg::IDX_CONFIG, 8'h08);
    v = $random(seed) % 1024;
    temp <= v[10:0];
    wb(1'h1, tmc_pkg::IDX_TRIGGER, 8'h40);
    repeat (20) @(posedge clk_i);
    rd(tmc_pkg::IDX_TRIGGER, 8'h40);
    wb(1'h1, tmc_pkg::IDX_CONFIG, 8'hC0);
    poll(tmc_pkg::IDX_TRIGGER, 8'h40);
    result_chk(v);
    stall <= 1'h0;
    $display("config and battery test done");
    for (n = 1; n < 7; n++) begin
      power_state_i <= 2'h0;
      wb(1'h1, tmc_pkg::IDX_CONFIG, 8'h40 | n[7:0]);
      poll(tmc_pkg::IDX_CONFIG, 8'h08);
      wb(1'h1, tmc_pkg::IDX_TRIGGER, 8'h40);
      rd(tmc_pkg::IDX_TRIGGER, 8'h00);
      power_state_i <= (n == 6) ? 2'h0 : {1'h1, n[0]};
      v = $random(seed) % 1024;
      temp <= v[10:0];
      tick((2 ** (3 + n)) - 1);
      repeat (3) @(posedge clk_i);
      chk1(sense_req_o.enable, 1'h0);
      tick(1);
      wait_en(1'h1);
      chk1(sense_req_o.enable, 1'h1);
      chk1(sense_req_o.supply_main, n == 6);
      chk1(sense_req_o.battery_sel | sense_req_o.battery_meas, 1'h0);
      wait_en(1'h0);
      result_chk(v);
    end
    $display("periodic test done");
    power_state_i <= 2'h2;
    wb(1'h1, tmc_pkg::IDX_CONFIG, 8'h07);
    poll(tmc_pkg::IDX_CONFIG, 8'h08);
    n = 0;
    repeat (40) begin
      @(posedge clk_i);
      if (sense_req_o.enable === 1'h1 && k == 0) n++;
      k = (sense_req_o.enable === 1'h1) ? 1 : 0;
    end
    chk1(n >= 3, 1'h1);
    wb(1'h1, tmc_pkg::IDX_CONFIG, 8'h00);
    poll(tmc_pkg::IDX_CONFIG, 8'h08);
    $display("continuous test done");
    close_out();
  end
endmodule // test_temperature_measure_control
`default_nettype wire

// ==== test/tmc_sensor_model.sv ====
// behavioural sensing oscillator answering measurement requests
`timescale 1ns/100ps
`default_nettype none
module tmc_sensor_model (
  input  wire logic                    clk_i,
  input  wire tmc_pkg::tmc_sense_req_t req_i,
  input  wire logic [7:0]              lat_i,
  input  wire logic [10:0]             temp_i,
  input  wire logic [7:0]              batt_i,
  input  wire logic                    stall_i,
  output var  tmc_pkg::tmc_sense_rsp_t rsp_o
);
  logic [7:0]  cnt_reg  = 8'h00;
  logic [18:0] junk_reg = 19'h2A5A5;
  logic        fin;
  // a weak battery supply never finishes until main supply is chosen
  assign fin = req_i.enable && (cnt_reg >= lat_i) &&
               (req_i.supply_main || !stall_i);
  always_ff @(posedge clk_i) begin
    cnt_reg  <= req_i.enable ? cnt_reg + 8'h01 : 8'h00;
    junk_reg <= ~junk_reg;
  end
  // result lines carry noise outside the done cycle
  always_comb begin
    rsp_o = {1'h0, junk_reg};
    if (fin) begin
      rsp_o.done   = 1'h1;
      rsp_o.result = temp_i;
      if (req_i.battery_meas) begin
        rsp_o.battery = batt_i;
      end
    end
  end
endmodule // tmc_sensor_model
`default_nettype wire

// ==== verilog/tmc_commit_timer.sv ====
// busy timer for the configuration byte commit
`timescale 1ns/100ps
`default_nettype none
module tmc_commit_timer #(
  parameter int CYCLES = tmc_pkg::COMMIT_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output var  logic busy_o,
  output var  logic done_o
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_reg;

  initial begin
    if (CYCLES < 1) $error("commit cycles must be at least one");
  end

  // busy from accepted write until the count runs out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        cnt_reg <= CW'(CYCLES - 1);
        busy_o  <= 1'b1;
      end else if (busy_o) begin
        if (cnt_reg == '0) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 1'b1;
        end
      end
    end
  end
endmodule // tmc_commit_timer
`default_nettype wire

// ==== verilog/tmc_period_timer.sv ====
// seconds counter that schedules periodic measurements
`timescale 1ns/100ps
`default_nettype none
module tmc_period_timer #(
  parameter int CNT_W = 10
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       restart_i,
  input  wire logic       tick_i,
  input  wire logic [2:0] sel_i,
  output var  logic       due_o
);
  logic [CNT_W-1:0] sec_reg;

  initial begin
    if (CNT_W < 10) $error("counter too narrow for longest interval");
  end

  function automatic logic [CNT_W-1:0] last_sec(input logic [2:0] s);
    last_sec = CNT_W'((1 << (tmc_pkg::PER_EXP_BASE + int'(s))) - 1);
  endfunction

  // interval 2^(3+sel) seconds, restarted on a new selector [RULE8]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec_reg <= '0;
      due_o   <= 1'b0;
    end else begin
      due_o <= 1'b0;
      if (restart_i) begin
        sec_reg <= '0; // [RULE16]
      end else if (tick_i && sel_i != tmc_pkg::PER_MANUAL &&
                   sel_i != tmc_pkg::PER_CONTINUOUS) begin
        if (sec_reg >= last_sec(sel_i)) begin
          sec_reg <= '0;
          due_o   <= 1'b1;
        end else begin
          sec_reg <= sec_reg + 1'b1;
        end
      end
    end
  end

  a_restart_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    restart_i |=> sec_reg == '0 && !due_o) // [RULE16]
    else $error("period count not restarted");
endmodule // tmc_period_timer
`default_nettype wire

// ==== verilog/tmc_top.sv ====
// temperature measure control: register slave, scheduler, sensor link
//
// Operation
// RULE1: full-power or brownout: setting trigger bit starts one measurement.
// RULE2: software polls trigger until zero before reading result or retrigger.
// RULE3: display-only and sleep: sensor woken at period selector rate.
// RULE4: result upper eight bits in one byte, lower three in next bits 7:5.
// RULE5: result is 11-bit two's complement, -1024 to +1023.
// RULE6: brownout: software sets supply and battery selectors equal.
// RULE7: busy flag while committing config byte; writes ignored, up to 6 ms.
// RULE8: period 0 manual, 1..6 give 2^(3+n) s, 7 continuous.
// RULE9: periodic measurements may be enabled in every power state.
// RULE10: measurement keeps working in sleep with the processor halted.
// RULE11: firmware may switch supply to main if battery measurement stalls.
// RULE12: trigger cleared at completion, ignored in display-only and sleep.
// RULE13: trigger works only while period selector is zero.
// RULE14: battery enable set: battery also measured with each temperature.
// RULE15: supply selector: one main digital supply, zero RTC battery. Here RTC battery is forced in display-only and sleep.
// RULE16: period timed from one-second tick, restarted on selector write.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module tmc_top #(
  parameter int COMMIT_CYCLES = tmc_pkg::COMMIT_CYCLES
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // wishbone classic slave
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [15:0]            adr_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            dat_i,
  output var  logic [31:0]            dat_o,
  output var  logic                   ack_o,
  // system
  input  wire logic [1:0]             power_state_i,
  input  wire logic                   sec_tick_i,
  output var  logic                   irq_o,
  // sensing oscillator circuit
  output var  tmc_pkg::tmc_sense_req_t sense_req_o,
  input  wire tmc_pkg::tmc_sense_rsp_t sense_rsp_i
);

  // ***************************************************
  // checks
  // ***************************************************
  initial begin
    if (COMMIT_CYCLES < 1) $error("commit cycles must be at least one");
  end

  // ***************************************************
  // declarations
  // ***************************************************
  tmc_pkg::tmc_state_t            state_reg;
  logic [tmc_pkg::RESULT_W-1:0]   result_reg;
  logic [tmc_pkg::BATTERY_W-1:0]  battery_reg;
  logic [2:0]                     period_reg;
  logic                           supply_reg;
  logic                           bsel_reg;
  logic                           bat_en_reg;
  logic [7:0]                     cfg_pend_reg;
  logic                           trigger_reg;
  logic                           due_pend_reg;
  logic [tmc_pkg::IRQ_W-1:0]      irq_stat_reg;
  logic [tmc_pkg::IRQ_W-1:0]      irq_mask_reg;
  logic [31:0]                    dat_next;
  logic                           wb_req;
  logic                           wb_wr;
  logic                           cfg_busy;
  logic                           cfg_done;
  logic                           period_due;
  logic                           awake;
  logic                           trig_go;
  logic                           auto_go;
  logic                           meas_go;
  logic                           meas_end;
  logic                           cfg_wr;
  logic                           cfg_take;
  logic [tmc_pkg::IRQ_W-1:0]      irq_event;

  function automatic logic hit(input logic [15:0] a,
                               input logic [13:0] idx);
    hit = (a[15:2] == idx);
  endfunction

  // ***************************************************
  // bus request decode
  // ***************************************************
  assign wb_req = cyc_i && stb_i && !ack_o;
  assign wb_wr  = wb_req && we_i && sel_i[0];
  assign cfg_wr = wb_wr && hit(adr_i, tmc_pkg::IDX_CONFIG);
  assign cfg_take = cfg_wr && !cfg_busy; // [RULE7]

  // ***************************************************
  // measurement start conditions
  // ***************************************************
  assign awake = power_state_i == tmc_pkg::TMC_FULL_POWER ||
                 power_state_i == tmc_pkg::TMC_BROWNOUT;

  // manual start only when awake, manual mode and idle
  assign trig_go = wb_wr && hit(adr_i, tmc_pkg::IDX_TRIGGER) &&
                   dat_i[tmc_pkg::TRIG_BIT] && awake &&
                   period_reg == tmc_pkg::PER_MANUAL &&
                   state_reg == tmc_pkg::TMC_IDLE; // [RULE1] [RULE13] [RULE12]

  // periodic start in any power state, halted processor or not
  assign auto_go = state_reg == tmc_pkg::TMC_IDLE && !trig_go && // [RULE9]
                   (due_pend_reg || period_due || // [RULE3] [RULE10]
                    period_reg == tmc_pkg::PER_CONTINUOUS);

  assign meas_go  = trig_go || auto_go;
  assign meas_end = state_reg == tmc_pkg::TMC_MEAS && sense_rsp_i.done;

  // ***************************************************
  // helper timers
  // ***************************************************
  tmc_commit_timer #(
    .CYCLES (COMMIT_CYCLES)
  ) u_commit (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (cfg_take),
    .busy_o  (cfg_busy),
    .done_o  (cfg_done)
  );

  tmc_period_timer #(
    .CNT_W (10)
  ) u_period (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .restart_i (cfg_done),
    .tick_i    (sec_tick_i),
    .sel_i     (period_reg),
    .due_o     (period_due)
  );

  // ***************************************************
  // configuration byte: captured on write, applied at commit end
  // ***************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_pend_reg <= tmc_pkg::CFG_RESET;
    end else if (cfg_take) begin
      cfg_pend_reg <= dat_i[7:0]; // [RULE7]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_reg <= tmc_pkg::CFG_RESET[tmc_pkg::CFG_PER_MSB:0];
      supply_reg <= tmc_pkg::CFG_RESET[tmc_pkg::CFG_SUPPLY_BIT];
      bsel_reg   <= tmc_pkg::CFG_RESET[tmc_pkg::CFG_BSEL_BIT];
      bat_en_reg <= tmc_pkg::CFG_RESET[tmc_pkg::CFG_BATEN_BIT];
    end else if (cfg_done) begin
      period_reg <= cfg_pend_reg[tmc_pkg::CFG_PER_MSB:0]; // [RULE8]
      supply_reg <= cfg_pend_reg[tmc_pkg::CFG_SUPPLY_BIT];
      bsel_reg   <= cfg_pend_reg[tmc_pkg::CFG_BSEL_BIT];
      bat_en_reg <= cfg_pend_reg[tmc_pkg::CFG_BATEN_BIT];
    end
  end

  // ***************************************************
  // measurement sequencing
  // ***************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= tmc_pkg::TMC_IDLE;
    end else begin
      case (state_reg)
        tmc_pkg::TMC_IDLE: begin
          if (meas_go) begin
            state_reg <= tmc_pkg::TMC_MEAS;
          end
        end
        tmc_pkg::TMC_MEAS: begin
          if (sense_rsp_i.done) begin
            state_reg <= tmc_pkg::TMC_IDLE;
          end
        end
        default: begin
          state_reg <= tmc_pkg::TMC_IDLE;
        end
      endcase
    end
  end

  // a due tick seen while busy is held until the sensor is free
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      due_pend_reg <= 1'b0;
    end else if (auto_go || period_reg == tmc_pkg::PER_MANUAL) begin
      due_pend_reg <= 1'b0;
    end else if (period_due) begin
      due_pend_reg <= 1'b1;
    end
  end

  // trigger reads one until the sensor reports done
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trigger_reg <= 1'b0;
    end else if (trig_go) begin
      trigger_reg <= 1'b1; // [RULE1]
    end else if (meas_end) begin
      trigger_reg <= 1'b0; // [RULE12]
    end
  end

  // sensor enable and battery fields latched at each start; supply_main follows config every cycle while awake, held low in display-only and sleep
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sense_req_o <= '0;
    end else begin
      if (meas_go) begin
        sense_req_o.enable       <= 1'b1;
        sense_req_o.battery_meas <= bat_en_reg; // [RULE14]
        sense_req_o.battery_sel  <= bsel_reg;
      end else if (meas_end) begin
        sense_req_o.enable       <= 1'b0;
        sense_req_o.battery_meas <= 1'b0;
      end
      sense_req_o.supply_main <= supply_reg && awake; // [RULE15]
    end
  end

  // result kept whole as two's complement; split only on read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_reg  <= '0;
      battery_reg <= '0;
    end else if (meas_end) begin
      result_reg <= sense_rsp_i.result; // [RULE5]
      if (sense_req_o.battery_meas) begin
        battery_reg <= sense_rsp_i.battery; // [RULE14]
      end
    end
  end

  // ***************************************************
  // interrupt status, mask and output
  // ***************************************************
  assign irq_event[tmc_pkg::IRQ_MEAS_BIT] = meas_end;
  assign irq_event[tmc_pkg::IRQ_CFG_BIT]  = cfg_done;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= '0;
    end else if (wb_wr && hit(adr_i, tmc_pkg::IDX_IRQ_STAT)) begin
      irq_stat_reg <= (irq_stat_reg & ~dat_i[tmc_pkg::IRQ_W-1:0]) |
                      irq_event;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_event;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_reg <= '0;
    end else if (wb_wr && hit(adr_i, tmc_pkg::IDX_IRQ_MASK)) begin
      irq_mask_reg <= dat_i[tmc_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ***************************************************
  // read data and acknowledge
  // ***************************************************
  always_comb begin
    dat_next = '0;
    case (adr_i[15:2])
      tmc_pkg::IDX_RESULT_HI: begin
        dat_next[7:0] = result_reg[10:3]; // [RULE4]
      end
      tmc_pkg::IDX_RESULT_LO: begin
        dat_next[7:tmc_pkg::LO_FIELD_LSB] = result_reg[2:0]; // [RULE4]
      end
      tmc_pkg::IDX_BATTERY: begin
        dat_next[7:0] = battery_reg;
      end
      tmc_pkg::IDX_CONFIG: begin
        dat_next[tmc_pkg::CFG_BSEL_BIT]   = bsel_reg;
        dat_next[tmc_pkg::CFG_SUPPLY_BIT] = supply_reg;
        dat_next[tmc_pkg::CFG_BATEN_BIT]  = bat_en_reg;
        dat_next[tmc_pkg::CFG_BUSY_BIT]   = cfg_busy; // [RULE7]
        dat_next[tmc_pkg::CFG_PER_MSB:0]  = period_reg;
      end
      tmc_pkg::IDX_TRIGGER: begin
        dat_next[tmc_pkg::TRIG_BIT] = trigger_reg;
      end
      tmc_pkg::IDX_IRQ_STAT: begin
        dat_next[tmc_pkg::IRQ_W-1:0] = irq_stat_reg;
      end
      tmc_pkg::IDX_IRQ_MASK: begin
        dat_next[tmc_pkg::IRQ_W-1:0] = irq_mask_reg;
      end
      default: begin
        dat_next = '0;
      end
    endcase
  end

  // one wait state; unmapped addresses answer with zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= wb_req;
      if (wb_req && !we_i) begin
        dat_o <= dat_next;
      end
    end
  end

  // ***************************************************
  // assertions
  // ***************************************************
  a_trig_start: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
    trig_go |=> sense_req_o.enable && trigger_reg)
    else $error("trigger did not start a measurement");
  a_trig_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
    (state_reg == tmc_pkg::TMC_IDLE && wb_wr &&
     hit(adr_i, tmc_pkg::IDX_TRIGGER) &&
     (!awake || period_reg != tmc_pkg::PER_MANUAL))
    |=> !trigger_reg)
    else $error("trigger accepted outside manual awake mode");
  a_trig_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE12]
    meas_end |=> !trigger_reg && !sense_req_o.enable)
    else $error("trigger not cleared at completion");
  a_period_run: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    (period_due && state_reg == tmc_pkg::TMC_IDLE && !trig_go)
    |=> sense_req_o.enable)
    else $error("periodic measurement not started");
  a_continuous_run: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
    (period_reg == tmc_pkg::PER_CONTINUOUS && meas_end && !cfg_done)
    |=> ##1 sense_req_o.enable)
    else $error("continuous mode did not restart");
  a_busy_lock: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    (cfg_busy && cfg_wr) |=> $stable(cfg_pend_reg))
    else $error("config write taken while busy");
  a_result_split: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
    (wb_req && !we_i && hit(adr_i, tmc_pkg::IDX_RESULT_LO))
    |=> dat_o[7:tmc_pkg::LO_FIELD_LSB] == $past(result_reg[2:0]) &&
        dat_o[4:0] == 5'h00)
    else $error("low result byte misplaced");
  a_result_capture: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
    meas_end |=> result_reg == $past(sense_rsp_i.result))
    else $error("result not captured");
  a_supply_sleep: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE15]
    !awake |=> !sense_req_o.supply_main)
    else $error("main supply chosen in low-power state");
  a_battery_meas: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE14]
    meas_go |=> sense_req_o.battery_meas == $past(bat_en_reg))
    else $error("battery measurement flag wrong");

endmodule // tmc_top
`default_nettype wire
